// [net_cfg_pkg.sv]
// Package: register map, reset values and carrier type for the network configuration bank
package net_cfg_pkg;

  localparam int NUM_REGS = 15;
  localparam int ADDR_W = 12;
  localparam int SLOT_W = 4;

  typedef logic [15:0] word_type;

  // Register slots, in map order
  localparam logic [SLOT_W-1:0] SLOT_CFG = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_MAC_HI = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_MAC_MID = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_MAC_LO = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_IP_LO = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_IP_HI = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_MASK_LO = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_MASK_HI = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_GW_LO = 4'h8;
  localparam logic [SLOT_W-1:0] SLOT_GW_HI = 4'h9;
  localparam logic [SLOT_W-1:0] SLOT_TCP_PORT = 4'hA;
  localparam logic [SLOT_W-1:0] SLOT_SIP_LO = 4'hB;
  localparam logic [SLOT_W-1:0] SLOT_SIP_HI = 4'hC;
  localparam logic [SLOT_W-1:0] SLOT_UDP_PORT = 4'hD;
  localparam logic [SLOT_W-1:0] SLOT_PKT_SIZE = 4'hE;

  // Register index; byte address is four times the index
  localparam logic [9:0] REG_INDEX [NUM_REGS] = '{
    10'h240, 10'h241, 10'h242, 10'h243, 10'h244, 10'h245, 10'h246, 10'h247,
    10'h248, 10'h249, 10'h24B, 10'h24C, 10'h24D, 10'h24E, 10'h259};

  // MAC words have no defined power-up value
  localparam word_type MAC_RESET = 16'h0000;

  localparam word_type REG_RESET [NUM_REGS] = '{
    16'h0006, MAC_RESET, MAC_RESET, MAC_RESET, 16'h000A, 16'hC0A8, 16'hFF00, 16'hFFFF,
    16'h0001, 16'hC0A8, 16'h2711, 16'h0001, 16'hE000, 16'h2712, 16'h0578};

  localparam int CFG_DHCP_BIT = 0;
  localparam int CFG_UDP_BIT = 1;
  localparam int CFG_CRC_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic dhcp_en;
    logic udp_stream_en;
    logic ignore_crc;
    logic [47:0] mac;
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] gateway;
    logic [15:0] tcp_port;
    logic [31:0] stream_ip;
    logic [15:0] stream_port;
    logic [15:0] packet_size;
    logic mac_apply;
    logic ip_apply;
    logic stream_apply;
  } net_cfg_type;

endpackage

// [network_config_register_bank.sv]
// Network configuration register bank with AXI4-Lite slave and staged multi-word commits
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Config bit 0 enables DHCP, resets 0006
// - Config bit 1 enables UDP streaming
// - Config bit 2 ignores UDP checksum
// - MAC held in three words, high first
// - Only lowest MAC word write applies MAC
// - IP address words, resets 000A and C0A8
// - Subnet mask words, resets FF00 and FFFF
// - Gateway words, resets 0001 and C0A8
// - Gateway high write applies IP, mask, gateway
// - Control TCP port register, reset 2711
// - Stream address words; high write applies it
// - Stream UDP port register, reset 2712
// - Stream packet size register, reset 0578
module network_config_register_bank
  import net_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output var net_cfg_type NET_CFG
);

  function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [SLOT_W:0] r;
    r = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (a[ADDR_W-1:2] == REG_INDEX[i]) begin
        r = {1'b1, SLOT_W'(i)};
      end
    end
    return r;
  endfunction

  word_type regs_ff [NUM_REGS];
  logic [ADDR_W-1:0] awaddr_ff;
  logic aw_full_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_full_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [47:0] mac_act_ff;
  logic [31:0] ip_act_ff;
  logic [31:0] mask_act_ff;
  logic [31:0] gw_act_ff;
  logic [31:0] sip_act_ff;
  logic mac_apply_ff;
  logic ip_apply_ff;
  logic stream_apply_ff;

  // Write decode: a missed lookup yields slot 0, so indexing stays in range
  wire logic [SLOT_W:0] wr_lu = slot_of(awaddr_ff);
  wire logic wr_hit = wr_lu[SLOT_W];
  wire logic [SLOT_W-1:0] wr_slot = wr_lu[SLOT_W-1:0];
  wire logic wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire logic wr_en = wr_fire & wr_hit;
  wire word_type wr_old = regs_ff[wr_slot];
  wire word_type wr_val = {wstrb_ff[1] ? wdata_ff[15:8] : wr_old[15:8],
                           wstrb_ff[0] ? wdata_ff[7:0] : wr_old[7:0]};
  wire logic mac_commit = wr_en & (wr_slot == SLOT_MAC_LO);
  wire logic ip_commit = wr_en & (wr_slot == SLOT_GW_HI);
  wire logic sip_commit = wr_en & (wr_slot == SLOT_SIP_HI);

  // Read decode
  wire logic [SLOT_W:0] rd_lu = slot_of(S_AXI_ARADDR);
  wire logic rd_hit = rd_lu[SLOT_W];
  wire logic [SLOT_W-1:0] rd_slot = rd_lu[SLOT_W-1:0];
  wire logic rd_fire = S_AXI_ARVALID & ~rvalid_ff;
  wire word_type rd_word = rd_hit ? regs_ff[rd_slot] : 16'h0000;

  assign S_AXI_AWREADY = ~aw_full_ff;
  assign S_AXI_WREADY = ~w_full_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  // Staged storage; every word reads back as written, committed or not
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= REG_RESET[i];
      end
    end else if (wr_en) begin
      regs_ff[wr_slot] <= wr_val;
    end
  end

  // Address and data are held separately so they may arrive in either order
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      aw_full_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (wr_fire) begin
      aw_full_ff <= 1'b0;
    end else if (S_AXI_AWVALID && !aw_full_ff) begin
      aw_full_ff <= 1'b1;
      awaddr_ff <= S_AXI_AWADDR;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      w_full_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (wr_fire) begin
      w_full_ff <= 1'b0;
    end else if (S_AXI_WVALID && !w_full_ff) begin
      w_full_ff <= 1'b1;
      wdata_ff <= S_AXI_WDATA;
      wstrb_ff <= S_AXI_WSTRB;
    end
  end

  // Unmapped writes are dropped and answered with SLVERR
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Unmapped reads return zero with SLVERR
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {16'h0000, rd_word};
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Active settings change only on the commit word; the written word is taken
  // straight from the merged write value wr_val so the new value applies in the same cycle it is stored
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      mac_act_ff <= {REG_RESET[SLOT_MAC_HI], REG_RESET[SLOT_MAC_MID], REG_RESET[SLOT_MAC_LO]};
      mac_apply_ff <= 1'b0;
    end else begin
      mac_apply_ff <= mac_commit;
      if (mac_commit) begin
        mac_act_ff <= {regs_ff[SLOT_MAC_HI], regs_ff[SLOT_MAC_MID], wr_val};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ip_act_ff <= {REG_RESET[SLOT_IP_HI], REG_RESET[SLOT_IP_LO]};
      mask_act_ff <= {REG_RESET[SLOT_MASK_HI], REG_RESET[SLOT_MASK_LO]};
      gw_act_ff <= {REG_RESET[SLOT_GW_HI], REG_RESET[SLOT_GW_LO]};
      ip_apply_ff <= 1'b0;
    end else begin
      ip_apply_ff <= ip_commit;
      if (ip_commit) begin
        ip_act_ff <= {regs_ff[SLOT_IP_HI], regs_ff[SLOT_IP_LO]};
        mask_act_ff <= {regs_ff[SLOT_MASK_HI], regs_ff[SLOT_MASK_LO]};
        gw_act_ff <= {wr_val, regs_ff[SLOT_GW_LO]};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sip_act_ff <= {REG_RESET[SLOT_SIP_HI], REG_RESET[SLOT_SIP_LO]};
      stream_apply_ff <= 1'b0;
    end else begin
      stream_apply_ff <= sip_commit;
      if (sip_commit) begin
        sip_act_ff <= {wr_val, regs_ff[SLOT_SIP_LO]};
      end
    end
  end

  // Single-word settings act directly from their register
  always_comb begin
    NET_CFG.dhcp_en = regs_ff[SLOT_CFG][CFG_DHCP_BIT];
    NET_CFG.udp_stream_en = regs_ff[SLOT_CFG][CFG_UDP_BIT];
    NET_CFG.ignore_crc = regs_ff[SLOT_CFG][CFG_CRC_BIT];
    NET_CFG.mac = mac_act_ff;
    NET_CFG.ip = ip_act_ff;
    NET_CFG.mask = mask_act_ff;
    NET_CFG.gateway = gw_act_ff;
    NET_CFG.tcp_port = regs_ff[SLOT_TCP_PORT];
    NET_CFG.stream_ip = sip_act_ff;
    NET_CFG.stream_port = regs_ff[SLOT_UDP_PORT];
    NET_CFG.packet_size = regs_ff[SLOT_PKT_SIZE];
    NET_CFG.mac_apply = mac_apply_ff;
    NET_CFG.ip_apply = ip_apply_ff;
    NET_CFG.stream_apply = stream_apply_ff;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_cfg_write;
    wr_en && (wr_slot == SLOT_CFG);
  endsequence

  sequence s_mac_stage_write;
    wr_en && ((wr_slot == SLOT_MAC_HI) || (wr_slot == SLOT_MAC_MID));
  endsequence

  sequence s_ip_stage_write;
    wr_en && (wr_slot >= SLOT_IP_LO) && (wr_slot <= SLOT_GW_LO);
  endsequence

  property p_cfg_reset;
    $rose(RESETN) |-> (regs_ff[SLOT_CFG] == 16'h0006) && !NET_CFG.dhcp_en;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");

  property p_dhcp_bit;
    s_cfg_write |=> NET_CFG.dhcp_en == $past(wr_val[CFG_DHCP_BIT]);
  endproperty
  a_dhcp_bit: assert property (p_dhcp_bit) else $error("DHCP enable not taken from bit 0");

  property p_udp_bit;
    s_cfg_write |=> NET_CFG.udp_stream_en == $past(wr_val[CFG_UDP_BIT]);
  endproperty
  a_udp_bit: assert property (p_udp_bit) else $error("UDP enable not taken from bit 1");

  property p_crc_bit;
    s_cfg_write |=> NET_CFG.ignore_crc == $past(wr_val[CFG_CRC_BIT]);
  endproperty
  a_crc_bit: assert property (p_crc_bit) else $error("checksum ignore not taken from bit 2");

  property p_mac_commit;
    mac_commit |=> NET_CFG.mac_apply &&
      (NET_CFG.mac == {$past(regs_ff[SLOT_MAC_HI]), $past(regs_ff[SLOT_MAC_MID]), $past(wr_val)});
  endproperty
  a_mac_commit: assert property (p_mac_commit) else $error("MAC not applied in byte order");

  property p_mac_stage;
    s_mac_stage_write |=> $stable(NET_CFG.mac) && !NET_CFG.mac_apply;
  endproperty
  a_mac_stage: assert property (p_mac_stage) else $error("upper MAC write changed active MAC");

  property p_ip_reset;
    $rose(RESETN) |-> (NET_CFG.ip == {16'hC0A8, 16'h000A});
  endproperty
  a_ip_reset: assert property (p_ip_reset) else $error("IP reset value wrong");

  property p_mask_reset;
    $rose(RESETN) |-> (NET_CFG.mask == {16'hFFFF, 16'hFF00});
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask reset value wrong");

  property p_gw_reset;
    $rose(RESETN) |-> (NET_CFG.gateway == {16'hC0A8, 16'h0001});
  endproperty
  a_gw_reset: assert property (p_gw_reset) else $error("gateway reset value wrong");

  property p_ip_stage;
    s_ip_stage_write |=> $stable(NET_CFG.ip) && $stable(NET_CFG.mask) && $stable(NET_CFG.gateway);
  endproperty
  a_ip_stage: assert property (p_ip_stage) else $error("staged IP word took effect early");

  property p_ip_commit;
    ip_commit |=> NET_CFG.ip_apply && (NET_CFG.ip == {$past(regs_ff[SLOT_IP_HI]), $past(regs_ff[SLOT_IP_LO])})
      && (NET_CFG.gateway == {$past(wr_val), $past(regs_ff[SLOT_GW_LO])});
  endproperty
  a_ip_commit: assert property (p_ip_commit) else $error("gateway high write did not apply");

  property p_tcp_port;
    $rose(RESETN) |-> NET_CFG.tcp_port == 16'h2711;
  endproperty
  a_tcp_port: assert property (p_tcp_port) else $error("TCP port reset value wrong");

  property p_stream_ip;
    sip_commit |=> NET_CFG.stream_apply && (NET_CFG.stream_ip == {$past(wr_val), $past(regs_ff[SLOT_SIP_LO])});
  endproperty
  a_stream_ip: assert property (p_stream_ip) else $error("stream address not applied");

  property p_stream_port;
    wr_en && (wr_slot == SLOT_UDP_PORT) |=> NET_CFG.stream_port == $past(wr_val);
  endproperty
  a_stream_port: assert property (p_stream_port) else $error("stream port not updated");

  property p_pkt_size;
    $rose(RESETN) |-> NET_CFG.packet_size == 16'h0578;
  endproperty
  a_pkt_size: assert property (p_pkt_size) else $error("packet size reset value wrong");

  property p_readback;
    rd_fire && rd_hit |=> S_AXI_RVALID && (S_AXI_RDATA == {16'h0000, $past(regs_ff[rd_slot])});
  endproperty
  a_readback: assert property (p_readback) else $error("read data differs from stored word");

  property p_mac_hold;
    !mac_commit |=> $stable(NET_CFG.mac);
  endproperty
  a_mac_hold: assert property (p_mac_hold) else $error("active MAC changed without commit");

  property p_ip_hold;
    !ip_commit |=> $stable(NET_CFG.ip) && $stable(NET_CFG.mask) && $stable(NET_CFG.gateway);
  endproperty
  a_ip_hold: assert property (p_ip_hold) else $error("active IP settings changed without commit");

  property p_mask_commit;
    ip_commit |=> NET_CFG.mask == {$past(regs_ff[SLOT_MASK_HI]), $past(regs_ff[SLOT_MASK_LO])};
  endproperty
  a_mask_commit: assert property (p_mask_commit) else $error("mask not applied on gateway high write");

  property p_stream_hold;
    !sip_commit |=> $stable(NET_CFG.stream_ip) && !NET_CFG.stream_apply;
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream address changed without commit");

  property p_stream_reset;
    $rose(RESETN) |-> (NET_CFG.stream_ip == {16'hE000, 16'h0001});
  endproperty
  a_stream_reset: assert property (p_stream_reset) else $error("stream address reset value wrong");

  property p_flags_reset;
    $rose(RESETN) |-> NET_CFG.udp_stream_en && NET_CFG.ignore_crc && (NET_CFG.stream_port == 16'h2712);
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("config flags reset value wrong");

  property p_tcp_write;
    wr_en && (wr_slot == SLOT_TCP_PORT) |=> NET_CFG.tcp_port == $past(wr_val);
  endproperty
  a_tcp_write: assert property (p_tcp_write) else $error("TCP port not updated");

  property p_stage_store;
    wr_en |=> regs_ff[$past(wr_slot)] == $past(wr_val);
  endproperty
  a_stage_store: assert property (p_stage_store) else $error("written word not stored");

endmodule

`default_nettype wire

// [tb_network_config_register_bank.sv]
// Self-checking bench for the network configuration register bank over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  import net_cfg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  net_cfg_type cfg;
  logic [4:0] bq [$];
  logic [33:0] rq [$];
  logic [4:0] bexp;
  logic [33:0] rexp;
  word_type model [NUM_REGS];
  logic [31:0] seed = 32'h0001_44E4;
  int checks = 0;
  int err_total = 0;
  int cycles = 0;
  // Holes inside and beside the map
  localparam logic [9:0] UNMAPPED_IDX [3] = '{10'h24A, 10'h23F, 10'h25A};

  network_config_register_bank dut (
    .CLK(clk), .RESETN(resetn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .NET_CFG(cfg)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  // Responses are sampled at the handshake edge, before the slave's own updates land
  always @(posedge clk) begin
    if (resetn && bvalid === 1'b1 && bready) begin
      bexp = bq.pop_front();
      `CHK({cfg.stream_apply, cfg.ip_apply, cfg.mac_apply, bresp}, bexp)
    end
    if (resetn && rvalid === 1'b1 && rready) begin
      rexp = rq.pop_front();
      `CHK({rresp, rdata}, rexp)
    end
  end

  // Address and data are offered together; each is dropped once taken
  task automatic wr(input logic [9:0] idx, input word_type d, input logic [3:0] s, input logic [1:0] er);
    logic a, w;
    logic [31:0] r;
    r = xs();
    a = 1'b0;
    w = 1'b0;
    @(posedge clk);
    bq.push_back({idx == REG_INDEX[SLOT_SIP_HI], idx == REG_INDEX[SLOT_GW_HI], idx == REG_INDEX[SLOT_MAC_LO], er});
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {r[31:16], d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!a && awready === 1'b1) begin a = 1'b1; awvalid <= 1'b0; end
      if (!w && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
    end while (!(a && w));
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [33:0] e);
    logic a;
    a = 1'b0;
    @(posedge clk);
    rq.push_back(e);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (!a && arready === 1'b1) begin a = 1'b1; arvalid <= 1'b0; end
    end while (!a);
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic wm(input int i, input word_type d, input logic [3:0] s);
    if (s[0]) model[i][7:0] = d[7:0];
    if (s[1]) model[i][15:8] = d[15:8];
    wr(REG_INDEX[i], d, s, RESP_OKAY);
  endtask

  task automatic wrand(input int i);
    logic [31:0] r;
    r = xs();
    wm(i, r[15:0], 4'h3);
  endtask

  task automatic rall();
    for (int i = 0; i < NUM_REGS; i++) rd(REG_INDEX[i], {RESP_OKAY, 16'h0000, model[i]});
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    model = REG_RESET;
  endtask

  task automatic chk_rst();
    rall();
    `CHK(cfg.dhcp_en, 1'b0)
    `CHK(cfg.udp_stream_en, 1'b1)
    `CHK(cfg.ignore_crc, 1'b1)
    `CHK(cfg.mac, 48'h0000_0000_0000)
    `CHK(cfg.ip, 32'hC0A8_000A)
    `CHK(cfg.mask, 32'hFFFF_FF00)
    `CHK(cfg.gateway, 32'hC0A8_0001)
    `CHK(cfg.tcp_port, 16'h2711)
    `CHK(cfg.stream_ip, 32'hE000_0001)
    `CHK(cfg.stream_port, 16'h2712)
    `CHK(cfg.packet_size, 16'h0578)
  endtask

  initial begin
    logic [31:0] r;
    do_reset();
    chk_rst();
    wrand(1);
    wrand(2);
    `CHK(cfg.mac, 48'h0000_0000_0000)
    wrand(3);
    `CHK(cfg.mac, {model[1], model[2], model[3]})
    for (int i = 4; i < 9; i++) wrand(i);
    rall();
    `CHK({cfg.ip, cfg.mask, cfg.gateway}, 96'hC0A8_000A_FFFF_FF00_C0A8_0001)
    wrand(9);
    `CHK({cfg.ip, cfg.mask, cfg.gateway}, {model[5], model[4], model[7], model[6], model[9], model[8]})
    wrand(11);
    `CHK(cfg.stream_ip, 32'hE000_0001)
    wrand(12);
    `CHK(cfg.stream_ip, {model[12], model[11]})
    for (int v = 0; v < 8; v++) begin
      r = xs();
      wm(0, {r[15:3], v[2:0]}, 4'h3);
      `CHK({cfg.ignore_crc, cfg.udp_stream_en, cfg.dhcp_en}, v[2:0])
    end
    wrand(10);
    wrand(13);
    wrand(14);
    `CHK({cfg.tcp_port, cfg.stream_port, cfg.packet_size}, {model[10], model[13], model[14]})
    for (int s = 0; s < 16; s++) begin
      r = xs();
      wm(14, r[15:0], s[3:0]);
      `CHK(cfg.packet_size, model[14])
    end
    for (int u = 0; u < 3; u++) begin
      wr(UNMAPPED_IDX[u], 16'h5A5A, 4'hF, RESP_SLVERR);
      rd(UNMAPPED_IDX[u], {RESP_SLVERR, 32'h0000_0000});
    end
    rall();
    do_reset();
    chk_rst();
    summarize();
  end
endmodule
`default_nettype wire
